// *** rss_reset_sequencer.sv ***
/*
 reset source sequencer: merges the reset sources, drives core, peripheral and
 test-port resets, keeps sticky cause flags, handles brown-out filtering and resampling.
 assumes a single 100 MHz clock; power monitors and the reset pin are asynchronous,
 the watchdog reset request is synchronous to clk_i. registers over classic wishbone.
*/
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rss_cfg.svh"
// Functional notes
// R1: six reset sources merge into internal reset
// R2: power-on resets core, peripherals, test port
// R3: pin resets core, peripherals, test-port pins only
// R4: brownout, software, watchdog, regulator spare test port
// R5: peripheral soft reset touches selected peripherals only
// R6: each reset sets its cause flag
// R7: flags sticky; pin reset clears the others
// R8: pin and power-on handling on main clock
// R9: power-on: hold until detector idle, then boot
// R10: power-on source acts at first power-up only
// R11: pin released, then internal release and boot
// R12: brownout reset disabled after reset
// R13: brownout raises interrupt or reset per config
// R14: brownout resets only with reset-select set
// R15: wait-filter resamples brownout after programmed delay
// R16: persisting condition leads to reset then boot; after the delay the code raises bor_irq_o only, with no reset
// R17: brownout condition clears after 500 us
// R18: optional noise filter on brownout interrupt path
// R19: peripheral reset on bit set then cleared
// R20: regulator flag set before internal reset
// R21: internal reset holds while any source active
// R22: reset pin synchronised before use
module rss_reset_sequencer import rss_pkg::*; #(
    parameter int NPERIPH = 32,
    parameter int BOR_CLR_CYC = `RSS_BOR_CLR_CYC,
    parameter int FILT_CYC = `RSS_FILT_CYC
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // reset sources
    input wire logic por_det_i,
    input wire logic rst_pin_n_i,
    input wire logic bor_det_i,
    input wire logic wdt_rst_i,
    input wire logic ldo_unreg_i,
    // reset outputs
    output logic core_rst_o,
    output logic [NPERIPH-1:0] periph_rst_o,
    output logic tap_rst_o,
    output logic pin_cfg_rst_o,
    output logic boot_fetch_o,
    output logic bor_irq_o
);
    localparam int CW = $clog2(BOR_CLR_CYC + 1);
    localparam int NC = `RSS_NCAUSE;
    localparam int HW = 4;

    typedef struct packed {
        rss_state_e st;
        logic [HW-1:0] hold_cnt;
        logic [NC-1:0] cause;
        logic bor_sel;
        logic bor_wait;
        logic bor_filt;
        logic ldo_en;
        logic [15:0] bor_dly;
        logic [NPERIPH-1:0] srst;
        logic [NPERIPH-1:0] prst;
        logic sw_req;
        logic bor_cond;
        logic bor_pend;
        logic [15:0] dly_cnt;
        logic [CW-1:0] clr_cnt;
        logic por_done;
        logic core_rel;
        logic tap_rel;
        logic pcfg;
        logic boot;
        logic irq;
        logic ack;
        logic [31:0] rdat;
    } rss_core_s;

    rss_core_s r;
    rss_core_s next_r;

    // leave reset in the hold state so core reset never dips for a cycle
    localparam rss_core_s RST_STATE = '{st: RS_HOLD, default: '0};

    logic [3:0] sync_q;
    logic por_s;
    logic pin_n_s;
    logic bor_s;
    logic ldo_s;
    logic bor_f;
    logic acc;
    logic wr;
    logic [31:0] m;
    logic [31:0] wv;
    logic [31:0] bctl;
    logic [31:0] rd;
    logic [NC-1:0] clr;
    logic [NC-1:0] set;
    logic por_act;
    logic ext_act;
    logic bor_in;
    logic bor_rst;
    logic ldo_act;
    logic any_sys;

    // power-on detector idles active so leaving reset starts a power-on
    rss_sync3 #(
        .W(4),
        .RST_VAL(4'h1)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .d_i({ldo_unreg_i, bor_det_i, ~rst_pin_n_i, por_det_i}),
        .q_o(sync_q)
    ); // [R22]

    assign por_s = sync_q[0];
    assign pin_n_s = ~sync_q[1];
    assign bor_s = sync_q[2];
    assign ldo_s = sync_q[3];

    rss_glitch_filter #(
        .CNT(FILT_CYC)
    ) u_filt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .en_i(r.bor_filt),
        .d_i(bor_s),
        .q_o(bor_f)
    ); // [R18]

    function automatic logic [31:0] byte_mask(input logic [3:0] sel);
        logic [31:0] v;
        v = '0;
        for (int i = 0; i < 4; i++) begin
            v[i*8 +: 8] = {8{sel[i]}};
        end
        return v;
    endfunction : byte_mask

    always_comb begin
        next_r = r;
        acc = wb_cyc_i & wb_stb_i & ~r.ack;
        wr = acc & wb_we_i;
        m = byte_mask(wb_sel_i);
        next_r.ack = acc;
        next_r.sw_req = 1'b0;
        next_r.irq = 1'b0;
        next_r.boot = 1'b0;
        clr = '0;
        bor_rst = 1'b0;

        // register images
        bctl = '0;
        bctl[`RSS_B_WAIT] = r.bor_wait;
        bctl[`RSS_B_SEL] = r.bor_sel;
        bctl[`RSS_B_FILT] = r.bor_filt;
        bctl[`RSS_B_DLY_HI:`RSS_B_DLY_LO] = r.bor_dly;
        rd = '0;
        unique case (wb_adr_i)
            `RSS_A_CAUSE: rd = 32'(r.cause);
            `RSS_A_BORCTL: rd = bctl;
            `RSS_A_PSRST: rd = 32'(r.srst);
            `RSS_A_LDOCTL: rd = 32'(r.ldo_en);
            `RSS_A_STATUS: rd = {26'h0, r.bor_pend, r.bor_cond, ~r.core_rel, r.por_done, r.st};
            default: rd = '0;
        endcase
        if (acc) begin
            next_r.rdat = wb_we_i ? 32'h0 : rd;
        end

        // writes take effect in the cycle the request is taken
        wv = (rd & ~m) | (wb_dat_i & m);
        if (wr) begin
            unique case (wb_adr_i)
                `RSS_A_CAUSE: clr = wv[NC-1:0] & m[NC-1:0];
                `RSS_A_BORCTL: begin
                    next_r.bor_wait = wv[`RSS_B_WAIT];
                    next_r.bor_sel = wv[`RSS_B_SEL];
                    next_r.bor_filt = wv[`RSS_B_FILT];
                    next_r.bor_dly = wv[`RSS_B_DLY_HI:`RSS_B_DLY_LO];
                end
                `RSS_A_PSRST: next_r.srst = wv[NPERIPH-1:0];
                `RSS_A_APPRST: next_r.sw_req = wv[`RSS_P_SYSREQ];
                `RSS_A_LDOCTL: next_r.ldo_en = wv[`RSS_L_EN];
                default: ;
            endcase
        end

        // source qualification
        next_r.por_done = r.por_done | ~por_s;
        por_act = por_s & ~r.por_done; // [R10]
        ext_act = ~pin_n_s; // [R22]
        ldo_act = ldo_s & r.ldo_en;

        // brownout: reset path sees the raw level, interrupt path the filtered one
        bor_in = r.bor_sel ? bor_s : bor_f; // [R18]
        if (r.bor_cond) begin
            if (r.clr_cnt == '0) begin
                next_r.bor_cond = 1'b0; // [R17]
            end else begin
                next_r.clr_cnt = r.clr_cnt - CW'(1);
            end
        end else if (bor_in) begin
            next_r.bor_cond = 1'b1;
            next_r.clr_cnt = CW'(BOR_CLR_CYC - 1); // [R17]
            if (r.bor_sel) begin
                bor_rst = 1'b1; // [R14]
            end else if (r.bor_wait) begin
                next_r.bor_pend = 1'b1; // [R15]
                next_r.dly_cnt = r.bor_dly;
            end else begin
                next_r.irq = 1'b1; // [R13]
            end
        end
        if (r.bor_pend) begin
            if (r.dly_cnt == '0) begin
                next_r.bor_pend = 1'b0;
                // vanished condition: nothing happens
                next_r.irq = bor_f; // [R15] [R16]
            end else begin
                next_r.dly_cnt = r.dly_cnt - 16'h1;
            end
        end

        any_sys = por_act | ext_act | bor_rst | r.sw_req | wdt_rst_i | ldo_act; // [R1] [R21]

        // cause flags: set beats a software clear
        set = '0;
        set[`RSS_C_EXT] = ext_act;
        set[`RSS_C_POR] = por_act;
        set[`RSS_C_BOR] = bor_rst;
        set[`RSS_C_SW] = r.sw_req;
        set[`RSS_C_WDT] = wdt_rst_i;
        set[`RSS_C_LDO] = ldo_act; // [R20]
        if (ext_act) begin
            next_r.cause = set; // [R7]
        end else begin
            next_r.cause = set | (r.cause & ~clr); // [R6] [R7]
        end

        // sequencer
        unique case (r.st)
            RS_RUN, RS_BOOT: begin
                if (any_sys) begin
                    next_r.st = RS_HOLD;
                end else begin
                    next_r.st = RS_RUN;
                end
            end
            RS_HOLD: begin
                if (!any_sys) begin
                    next_r.st = RS_STRETCH; // [R9] [R11]
                    next_r.hold_cnt = HW'(`RSS_HOLD_CYC - 1);
                end
            end
            RS_STRETCH: begin
                if (any_sys) begin
                    next_r.st = RS_HOLD; // [R21]
                end else if (r.hold_cnt == '0) begin
                    next_r.st = RS_BOOT;
                end else begin
                    next_r.hold_cnt = r.hold_cnt - HW'(1);
                end
            end
        endcase

        // a system reset returns control state to its defaults
        if (r.st == RS_HOLD) begin
            next_r.bor_sel = 1'b0; // [R12]
            next_r.bor_wait = 1'b0;
            next_r.bor_filt = 1'b0;
            next_r.ldo_en = 1'b0;
            next_r.bor_dly = '0;
            next_r.srst = '0;
            next_r.bor_pend = 1'b0;
        end

        // pulse on every bit that software drops
        next_r.prst = r.srst & ~next_r.srst; // [R5] [R19]
        // reset output lags the flags by one cycle
        next_r.core_rel = ~(r.st == RS_HOLD || r.st == RS_STRETCH); // [R20]
        next_r.boot = (r.st == RS_BOOT); // [R9] [R16]
        next_r.tap_rel = ~por_act; // [R2] [R4]
        next_r.pcfg = por_act | ext_act; // [R3]
    end

    // single clock: pin and power-on handling share it with the internal logic [R8]
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= RST_STATE;
        end else begin
            r <= next_r;
        end
    end

    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdat;
    assign core_rst_o = ~r.core_rel;
    assign periph_rst_o = {NPERIPH{~r.core_rel}} | r.prst; // [R2] [R3] [R5]
    assign tap_rst_o = ~r.tap_rel;
    assign pin_cfg_rst_o = r.pcfg;
    assign boot_fetch_o = r.boot;
    assign bor_irq_o = r.irq;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    property p_any_holds;
        any_sys |-> ##2 core_rst_o;
    endproperty
    a_any_holds: assert property (p_any_holds) else $error("source did not assert core reset"); // [R21]

    property p_ext_clears;
        (ext_act && !por_act && !wdt_rst_i && !ldo_act && !r.sw_req && !bor_rst)
            |=> r.cause == NC'(1 << `RSS_C_EXT);
    endproperty
    a_ext_clears: assert property (p_ext_clears) else $error("pin reset left other cause flags"); // [R7]

    property p_ext_no_tap;
        (ext_act && !por_act) |=> !tap_rst_o && pin_cfg_rst_o;
    endproperty
    a_ext_no_tap: assert property (p_ext_no_tap) else $error("pin reset touched test port"); // [R3]

    property p_tap_por;
        !$past(rst_i) |-> tap_rst_o == $past(por_act);
    endproperty
    a_tap_por: assert property (p_tap_por) else $error("test port reset without power-on"); // [R4]

    property p_bor_sel;
        bor_rst |-> r.bor_sel ##1 r.cause[`RSS_C_BOR];
    endproperty
    a_bor_sel: assert property (p_bor_sel) else $error("brownout reset without select"); // [R14]

    property p_sticky;
        (!wr && !ext_act) |=> (r.cause & $past(r.cause)) == $past(r.cause);
    endproperty
    a_sticky: assert property (p_sticky) else $error("cause flag lost"); // [R7]

    property p_ldo_order;
        (ldo_act && !core_rst_o && r.st == RS_RUN) |=> r.cause[`RSS_C_LDO] && !core_rst_o ##1 core_rst_o;
    endproperty
    a_ldo_order: assert property (p_ldo_order) else $error("regulator flag not ahead of reset"); // [R20]

    property p_boot;
        $fell(core_rst_o) |-> boot_fetch_o ##1 !boot_fetch_o;
    endproperty
    a_boot: assert property (p_boot) else $error("no boot fetch at release"); // [R9]

    property p_prst;
        $fell(r.srst[0]) |-> periph_rst_o[0];
    endproperty
    a_prst: assert property (p_prst) else $error("peripheral reset missing"); // [R19]

    property p_bor_clr;
        $rose(r.bor_cond) |-> r.clr_cnt == CW'(BOR_CLR_CYC - 1);
    endproperty
    a_bor_clr: assert property (p_bor_clr) else $error("brownout hold time wrong"); // [R17]

    property p_por_once;
        r.por_done |=> !tap_rst_o [*2];
    endproperty
    a_por_once: assert property (p_por_once) else $error("power-on reasserted"); // [R10]

    c_boot: cover property (boot_fetch_o);
    c_irq: cover property (bor_irq_o);
    c_prst: cover property (r.prst[0] && !core_rst_o);
    c_ext: cover property (ext_act ##1 pin_cfg_rst_o);
endmodule : rss_reset_sequencer

// *** rss_cfg.svh ***
/*
 reset sequencer constants: register offsets, field positions and timing counts.
 assumes a 100 MHz system clock and byte addressing on the register bus.
*/
`ifndef RSS_CFG_SVH
`define RSS_CFG_SVH
`define RSS_CLK_NS 10
// register byte offsets
`define RSS_A_CAUSE 8'h00
`define RSS_A_BORCTL 8'h04
`define RSS_A_PSRST 8'h08
`define RSS_A_APPRST 8'h0c
`define RSS_A_LDOCTL 8'h10
`define RSS_A_STATUS 8'h14
// reset_cause_flags bit positions
`define RSS_C_EXT 0
`define RSS_C_POR 1
`define RSS_C_BOR 2
`define RSS_C_SW 3
`define RSS_C_WDT 4
`define RSS_C_LDO 5
`define RSS_NCAUSE 6
// supply_fault_reset_ctrl fields
`define RSS_B_WAIT 0
`define RSS_B_SEL 1
`define RSS_B_FILT 2
`define RSS_B_DLY_LO 8
`define RSS_B_DLY_HI 23
// app_irq_reset_ctrl and regulator_fault_reset fields
`define RSS_P_SYSREQ 2
`define RSS_L_EN 0
// timing
`define RSS_HOLD_NS 100
`define RSS_HOLD_CYC ((`RSS_HOLD_NS + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_BOR_CLR_US 500
`define RSS_BOR_CLR_CYC ((`RSS_BOR_CLR_US * 1000 + `RSS_CLK_NS - 1) / `RSS_CLK_NS)
`define RSS_FILT_CYC 16
`endif

// *** rss_pkg.sv ***
/*
 reset sequencer types.
 assumes nothing beyond the compile order header, package, modules.
*/
package rss_pkg;
    typedef enum logic [1:0] {
        RS_RUN = 2'b00,
        RS_HOLD = 2'b01,
        RS_STRETCH = 2'b10,
        RS_BOOT = 2'b11
    } rss_state_e;
endpackage : rss_pkg

// *** rss_sync3.sv ***
/*
 three-stage synchroniser for a vector of asynchronous levels.
 assumes each bit is an independent level; output moves once stages two and three agree.
*/
`timescale 1ns/1ps
module rss_sync3 import rss_pkg::*; #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } rss_sync_s;

    rss_sync_s r;
    rss_sync_s next_r;

    always_comb begin
        next_r = r;
        next_r.s1 = d_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // stage one feeds only stage two
        next_r.q = (r.s2 & ~(r.s2 ^ r.s3)) | (r.q & (r.s2 ^ r.s3));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= {4{RST_VAL}};
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;
endmodule : rss_sync3

// *** rss_glitch_filter.sv ***
/*
 digital noise filter for one synchronised level.
 assumes the input is already on clk_i; when disabled the level passes with one cycle delay.
*/
`timescale 1ns/1ps
module rss_glitch_filter import rss_pkg::*; #(
    parameter int CNT = 16
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // level
    input wire logic en_i,
    input wire logic d_i,
    output logic q_o
);
    localparam int CW = $clog2(CNT + 1);

    typedef struct packed {
        logic q;
        logic [CW-1:0] cnt;
    } rss_filt_s;

    rss_filt_s r;
    rss_filt_s next_r;

    always_comb begin
        next_r = r;
        if (!en_i || d_i == r.q) begin
            next_r.cnt = '0;
            next_r.q = d_i;
        end else if (r.cnt == CW'(CNT - 1)) begin
            next_r.cnt = '0;
            next_r.q = d_i;
        end else begin
            next_r.cnt = r.cnt + CW'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign q_o = r.q;
endmodule : rss_glitch_filter

// *** rss_src_model.sv ***
/*
 supply monitor and reset pin model for the reset sequencer bench.
 assumes clk_i is the bench clock; the pin has a pull-up and idles high.
*/
`timescale 1ns/1ps
module rss_src_model #(
    parameter int PIN_MIN_CYC = 4
) (
    // clock
    input wire logic clk_i,
    // monitor and pin levels
    output logic por_det_o,
    output logic rst_pin_n_o,
    output logic bor_det_o,
    output logic ldo_unreg_o
);
    initial begin
        por_det_o = 1'b1;
        rst_pin_n_o = 1'b1;
        bor_det_o = 1'b0;
        ldo_unreg_o = 1'b0;
        repeat (30) @(posedge clk_i);
        por_det_o <= 1'b0; // ramp done, detector goes idle until pulse(0, ...) drives it again
    end

    task automatic drive(input int which, input logic v);
        case (which)
            0: por_det_o <= v;
            1: rst_pin_n_o <= !v;
            2: bor_det_o <= v;
            default: ldo_unreg_o <= v;
        endcase
    endtask : drive

    // which: 0 power-on, 1 pin, 2 brownout, 3 regulator
    task automatic pulse(input int which, input int n);
        int len;
        len = n;
        if (which == 1 && len < PIN_MIN_CYC) begin
            len = PIN_MIN_CYC; // pin never shorter than the minimum width
        end
        @(posedge clk_i);
        drive(which, 1'b1);
        repeat (len) @(posedge clk_i);
        drive(which, 1'b0);
    endtask : pulse
endmodule : rss_src_model

// *** tb_rss_reset_sequencer.sv ***
/*
 self-checking bench for the reset sequencer: wishbone master, watchdog stimulus, read monitor.
 assumes rss_src_model stands in for the monitors and the pin; short brownout counts.
*/
`timescale 1ns/1ps
`include "rss_cfg.svh"
`define TB_CHK(a, b) begin checks++; if ((a) !== (b)) begin fails++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb_rss_reset_sequencer import rss_pkg::*;;
    typedef struct {logic [31:0] d; logic [31:0] m;} rss_exp_s;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, wdt = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] dat = 32'h0, wb_dat_o, periph, per_seen = 32'h0;
    logic wb_ack_o, por, pin_n, bor, ldo, core, tap, cfg, boot, irq;
    logic saw_tap, saw_cfg, saw_core, saw_per;
    rss_exp_s expq[$];
    int fails = 0, checks = 0, cyc_cnt = 0, irq_cnt = 0, boot_cnt = 0;

    always #5 clk_i = ~clk_i;

    rss_src_model #(.PIN_MIN_CYC(4)) i_src (.clk_i(clk_i), .por_det_o(por), .rst_pin_n_o(pin_n),
        .bor_det_o(bor), .ldo_unreg_o(ldo));
    rss_reset_sequencer #(.NPERIPH(32), .BOR_CLR_CYC(20), .FILT_CYC(3)) i_dut (.clk_i(clk_i),
        .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
        .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .por_det_i(por), .rst_pin_n_i(pin_n),
        .bor_det_i(bor), .wdt_rst_i(wdt), .ldo_unreg_i(ldo), .core_rst_o(core), .periph_rst_o(periph),
        .tap_rst_o(tap), .pin_cfg_rst_o(cfg), .boot_fetch_o(boot), .bor_irq_o(irq));

    task automatic conclude;
        $display("checks=%0d fails=%0d", checks, fails);
        if (fails == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : conclude

    always @(posedge clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
        if (boot === 1'b1) boot_cnt <= boot_cnt + 1;
        // soft pulses only, core reset masks them
        if (core === 1'b0 && periph !== 32'h0) per_seen <= periph;
        if (cyc_cnt == 4000) begin
            fails++;
            conclude();
        end
    end

    // read monitor: oldest note against each read answer
    always @(posedge clk_i) begin
        rss_exp_s e;
        e = '{32'hffff_ffff, 32'h0};
        if (wb_ack_o === 1'b1 && we === 1'b0) begin
            if (expq.size() > 0) e = expq.pop_front();
            `TB_CHK(wb_dat_o & e.m, e.d)
        end
    end

    function automatic logic [31:0] cb(input int b);
        return 32'h1 << b;
    endfunction : cb

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1) @(posedge clk_i);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : wb

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
        expq.push_back('{d, m});
        wb(1'b0, a, 32'h0);
    endtask : rd

    task automatic wait_boot;
        int n;
        n = 0;
        {saw_tap, saw_cfg, saw_core, saw_per} = 4'h0;
        while (boot !== 1'b1 && n < 300) begin
            @(posedge clk_i);
            n++;
            if (tap === 1'b1) saw_tap = 1'b1;
            if (cfg === 1'b1) saw_cfg = 1'b1;
            if (core === 1'b1) saw_core = 1'b1;
            if (periph === 32'hffff_ffff) saw_per = 1'b1;
        end
        `TB_CHK(boot, 1'b1)
        @(posedge clk_i);
    endtask : wait_boot

    initial begin
        int b0, i0;
        logic [31:0] v;
        v = $urandom(32'h0e047f49);
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_boot();
        `TB_CHK({saw_tap, saw_cfg, saw_core, saw_per}, 4'hf)
        rd(`RSS_A_CAUSE, cb(`RSS_C_POR), cb(`RSS_C_POR));
        rd(`RSS_A_STATUS, 32'h4, 32'hffff_ffff);
        wb(1'b1, `RSS_A_CAUSE, 32'h3f);
        rd(`RSS_A_CAUSE, 32'h0, 32'hffff_ffff);
        rd(`RSS_A_BORCTL, 32'h0, 32'hffff_ffff);
        wb(1'b1, 8'hfc, 32'hffff_ffff);
        rd(8'hfc, 32'h0, 32'hffff_ffff);
        b0 = boot_cnt;
        i_src.pulse(0, 6);
        repeat (30) @(posedge clk_i);
        `TB_CHK(boot_cnt, b0)
        // watchdog held well past the stretch
        wdt <= 1'b1;
        repeat (20) @(posedge clk_i);
        `TB_CHK(core, 1'b1)
        wdt <= 1'b0;
        wait_boot();
        `TB_CHK({saw_tap, saw_per}, 2'b01)
        rd(`RSS_A_CAUSE, cb(`RSS_C_WDT), 32'hffff_ffff);
        wb(1'b1, `RSS_A_APPRST, cb(`RSS_P_SYSREQ));
        wait_boot();
        rd(`RSS_A_CAUSE, cb(`RSS_C_WDT) | cb(`RSS_C_SW), 32'hffff_ffff);
        rd(`RSS_A_APPRST, 32'h0, 32'hffff_ffff);
        wb(1'b1, `RSS_A_LDOCTL, cb(`RSS_L_EN));
        i_src.pulse(3, 6);
        wait_boot();
        rd(`RSS_A_CAUSE, 32'h38, 32'hffff_ffff);
        // enable was cleared by that reset
        b0 = boot_cnt;
        i_src.pulse(3, 6);
        repeat (40) @(posedge clk_i);
        `TB_CHK(boot_cnt, b0)
        i_src.pulse(1, 4 + $urandom_range(0, 7));
        wait_boot();
        `TB_CHK({saw_tap, saw_cfg, saw_core}, 3'b011)
        rd(`RSS_A_CAUSE, cb(`RSS_C_EXT), 32'hffff_ffff);
        v = $urandom() | 32'h1;
        b0 = boot_cnt;
        wb(1'b1, `RSS_A_PSRST, v);
        rd(`RSS_A_PSRST, v, 32'hffff_ffff);
        wb(1'b1, `RSS_A_PSRST, 32'h0);
        repeat (3) @(posedge clk_i);
        `TB_CHK(per_seen, v)
        `TB_CHK(boot_cnt, b0)
        // second brownout one cycle after the first falls inside the hold-off
        i0 = irq_cnt;
        i_src.pulse(2, 6);
        i_src.pulse(2, 3);
        repeat (40) @(posedge clk_i);
        `TB_CHK(irq_cnt, i0 + 1)
        i_src.pulse(2, 6);
        repeat (40) @(posedge clk_i);
        `TB_CHK(irq_cnt, i0 + 2)
        `TB_CHK(boot_cnt, b0)
        wb(1'b1, `RSS_A_BORCTL, (32'h8 << `RSS_B_DLY_LO) | cb(`RSS_B_WAIT) | cb(`RSS_B_FILT));
        i0 = irq_cnt;
        i_src.pulse(2, 3);
        repeat (60) @(posedge clk_i);
        `TB_CHK(irq_cnt, i0)
        i_src.pulse(2, 16);
        repeat (60) @(posedge clk_i);
        `TB_CHK(irq_cnt, i0 + 1)
        wb(1'b1, `RSS_A_BORCTL, cb(`RSS_B_SEL));
        i_src.pulse(2, 6);
        wait_boot();
        rd(`RSS_A_CAUSE, cb(`RSS_C_EXT) | cb(`RSS_C_BOR), 32'hffff_ffff);
        rd(`RSS_A_BORCTL, 32'h0, 32'hffff_ffff);
        repeat (3) @(posedge clk_i);
        conclude();
    end
endmodule : tb_rss_reset_sequencer
